// file: rtl/etg_gate.sv
`timescale 1ns/1ps
`include "etg_params.svh"
module etg_gate
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // trigger inputs
    input  wire logic        ext_trig_main,
    input  wire logic        ext_trig_extra_a,
    input  wire logic        ext_trig_extra_b,
    // gate
    output logic             gate_open
);
    import etg_pkg::*;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [31:0]  trigger_source_mask;
    logic [31:0]  external_gate_mode;
    logic [15:0]  pulse_width_limit;
    logic         run_enable;
    logic [31:0]  next_mask;
    logic [31:0]  next_mode;
    logic [15:0]  next_width;
    logic         next_run;
    logic [31:0]  next_prdata;
    logic         next_pslverr;
    logic         next_pready;
    logic         access;
    logic         hit;
    etg_state_t   state;

    assign access = psel && penable && !pready;

    always_comb
    begin
        next_mask    = trigger_source_mask;
        next_mode    = external_gate_mode;
        next_width   = pulse_width_limit;
        next_run     = run_enable;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        next_pready  = access;
        hit          = 1'b1;
        case (paddr[17:0])
            `ETG_ADDR_SOURCE_MASK: next_prdata = trigger_source_mask;
            `ETG_ADDR_GATE_MODE:   next_prdata = external_gate_mode;
            `ETG_ADDR_PULSE_WIDTH: next_prdata = {16'h0000, pulse_width_limit};
            `ETG_ADDR_CONTROL:     next_prdata = {31'h0, run_enable};
            `ETG_ADDR_STATUS:      next_prdata = {29'h0, gate_open,
                                                  state == ETG_ARMED, run_enable};
            default:
            begin
                next_prdata = 32'h00000000;
                hit         = 1'b0;
            end
        endcase
        if (paddr[31:18] != 14'h0000)
        begin
            hit         = 1'b0;
            next_prdata = 32'h00000000;
        end
        if (access)
        begin
            next_pslverr = !hit;
            if (pwrite && hit)
            begin
                case (paddr[17:0])
                    `ETG_ADDR_SOURCE_MASK: next_mask = pwdata;
                    `ETG_ADDR_GATE_MODE:   next_mode = pwdata;
                    // values below 2 are clamped so the counter never qualifies at once
                    `ETG_ADDR_PULSE_WIDTH: next_width = (pwdata[15:0] < `ETG_PW_MIN) ?
                                                        `ETG_PW_MIN : pwdata[15:0];
                    `ETG_ADDR_CONTROL:     next_run = pwdata[0];
                    default:               next_run = run_enable;
                endcase
            end
        end
        else
        begin
            next_prdata = prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trigger_source_mask <= `ETG_RST_SOURCE_MASK;
            external_gate_mode  <= `ETG_RST_GATE_MODE;
            pulse_width_limit   <= `ETG_RST_PULSE_WIDTH;
            run_enable          <= 1'b0;
            prdata              <= 32'h00000000;
            pready              <= 1'b0;
            pslverr             <= 1'b0;
        end
        else
        begin
            trigger_source_mask <= next_mask;
            external_gate_mode  <= next_mode;
            pulse_width_limit   <= next_width;
            run_enable          <= next_run;
            prdata              <= next_prdata;
            pready              <= next_pready;
            pslverr             <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    logic [2:0] raw_in;
    logic [2:0] sync_in;
    logic [2:0] admit;
    logic       trig;
    logic       trig_q;
    logic       run_q;
    logic       rise;
    logic       fall;
    logic       start;

    assign raw_in = {ext_trig_extra_b, ext_trig_extra_a, ext_trig_main};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            etg_sync u_sync
            (
                .pclk    (pclk),
                .presetn (presetn),
                .din     (raw_in[gi]),
                .dout    (sync_in[gi])
            );
        end
    endgenerate

    assign admit = {trigger_source_mask[`ETG_MASK_EXTRA_B_BIT],
                    trigger_source_mask[`ETG_MASK_EXTRA_A_BIT],
                    trigger_source_mask[`ETG_MASK_MAIN_BIT]};
    // masked sources idle high so they never look low or produce an edge
    assign trig  = &(sync_in | ~admit);
    assign rise  = trig && !trig_q;
    assign fall  = !trig && trig_q;
    assign start = run_enable && !run_q;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    etg_sel_t sel;

    always_comb
    begin
        case (external_gate_mode)
            `ETG_MODE_LOW_LEVEL:                      sel = ETG_SEL_LOW_LEVEL;
            (`ETG_MODE_FALLING | `ETG_MODE_TWO_EDGE): sel = ETG_SEL_FALL_TWO_EDGE;
            (`ETG_MODE_RISING | `ETG_MODE_LONGER):    sel = ETG_SEL_LONG_HIGH;
            (`ETG_MODE_FALLING | `ETG_MODE_LONGER):   sel = ETG_SEL_LONG_LOW;
            default:                                  sel = ETG_SEL_NONE;
        endcase
    end

    // ------------------------------------------------------------
    // gate engine
    // ------------------------------------------------------------
    logic [15:0]  width_cnt;
    logic [15:0]  next_cnt;
    logic         qualify;
    etg_state_t   next_state;
    logic         next_gate;

    // count lags the input by one sample, so >= means longer than the limit
    assign qualify = (width_cnt >= pulse_width_limit);

    always_comb
    begin
        next_state = state;
        next_gate  = gate_open;
        next_cnt   = width_cnt;
        // count samples while the level of interest holds
        if ((sel == ETG_SEL_LONG_HIGH && trig) || (sel == ETG_SEL_LONG_LOW && !trig))
        begin
            if (width_cnt != 16'hffff)
                next_cnt = width_cnt + 16'h0001;
        end
        else
        begin
            next_cnt = 16'h0000;
        end
        case (state)
            ETG_IDLE:
            begin
                next_gate = 1'b0;
                if (start && sel != ETG_SEL_NONE)
                    next_state = ETG_ARMED;
                if (start && sel == ETG_SEL_LOW_LEVEL && !trig)
                begin
                    next_state = ETG_OPEN;
                    next_gate  = 1'b1;
                end
            end
            ETG_ARMED:
            begin
                case (sel)
                    ETG_SEL_LOW_LEVEL:     next_gate = !trig;
                    ETG_SEL_FALL_TWO_EDGE: next_gate = fall;
                    ETG_SEL_LONG_HIGH:     next_gate = trig && qualify;
                    ETG_SEL_LONG_LOW:      next_gate = !trig && qualify;
                    default:               next_gate = 1'b0;
                endcase
                if (next_gate)
                    next_state = ETG_OPEN;
            end
            ETG_OPEN:
            begin
                case (sel)
                    ETG_SEL_LOW_LEVEL:     next_gate = !trig;
                    ETG_SEL_FALL_TWO_EDGE: next_gate = !fall;
                    ETG_SEL_LONG_HIGH:     next_gate = !fall;
                    ETG_SEL_LONG_LOW:      next_gate = !rise;
                    default:               next_gate = 1'b0;
                endcase
                // low-level re-arms; other modes too, each close waits for a new open
                if (!next_gate)
                    next_state = ETG_ARMED;
            end
            default:
            begin
                next_state = ETG_IDLE;
                next_gate  = 1'b0;
            end
        endcase
        if (!run_enable)
        begin
            next_state = ETG_IDLE;
            next_gate  = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state     <= ETG_IDLE;
            gate_open <= 1'b0;
            width_cnt <= 16'h0000;
            trig_q    <= 1'b1;
            run_q     <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            gate_open <= next_gate;
            width_cnt <= next_cnt;
            trig_q    <= trig;
            run_q     <= run_enable;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_low_open: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ETG_ARMED && sel == ETG_SEL_LOW_LEVEL && !trig && run_enable) |=> gate_open)
        else $error("low level did not open gate");
    chk_low_start: assert property (@(posedge pclk) disable iff (!presetn)
        (start && sel == ETG_SEL_LOW_LEVEL && !trig) |=> gate_open)
        else $error("low level at start did not open gate");
    chk_low_close: assert property (@(posedge pclk) disable iff (!presetn)
        (gate_open && sel == ETG_SEL_LOW_LEVEL && trig) |=> !gate_open)
        else $error("low level gate not closed on high");
    chk_two_edge_close: assert property (@(posedge pclk) disable iff (!presetn)
        (gate_open && sel == ETG_SEL_FALL_TWO_EDGE && fall) |=> !gate_open)
        else $error("second falling edge did not close gate");
    chk_two_edge_start: assert property (@(posedge pclk) disable iff (!presetn)
        (sel == ETG_SEL_FALL_TWO_EDGE && !gate_open && !fall) |=> !gate_open)
        else $error("gate opened without falling edge");
    chk_mask_ignore: assert property (@(posedge pclk) disable iff (!presetn)
        (!admit[0] && $stable(admit) && $stable(sync_in[2:1])) |-> $stable(trig))
        else $error("masked source reached trigger");
    chk_short_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (sel == ETG_SEL_LONG_HIGH && !gate_open && !qualify) |=> !gate_open)
        else $error("short pulse opened gate");
    chk_high_close: assert property (@(posedge pclk) disable iff (!presetn)
        (gate_open && sel == ETG_SEL_LONG_HIGH && fall) |=> !gate_open)
        else $error("long high gate not closed on fall");
    chk_low_pw_close: assert property (@(posedge pclk) disable iff (!presetn)
        (gate_open && sel == ETG_SEL_LONG_LOW && rise) |=> !gate_open)
        else $error("long low gate not closed on rise");
    chk_width_count: assert property (@(posedge pclk) disable iff (!presetn)
        (sel == ETG_SEL_LONG_LOW && !trig && $past(!trig) && width_cnt != 16'hffff
         && $past(sel == ETG_SEL_LONG_LOW)) |=> width_cnt == $past(width_cnt) + 16'h0001)
        else $error("pulse counter did not advance");
endmodule // etg_gate

// file: rtl/etg_params.svh
`ifndef ETG_PARAMS_SVH
`define ETG_PARAMS_SVH

// register indexes, and byte addresses at four bytes per index
`define ETG_IDX_SOURCE_MASK     16'h9dda
`define ETG_IDX_GATE_MODE       16'h9e3e
`define ETG_IDX_PULSE_WIDTH     16'hacb2
`define ETG_IDX_CONTROL         16'hb000
`define ETG_IDX_STATUS          16'hb001
`define ETG_ADDR_SOURCE_MASK    18'h27768
`define ETG_ADDR_GATE_MODE      18'h278f8
`define ETG_ADDR_PULSE_WIDTH    18'h2b2c8
`define ETG_ADDR_CONTROL        18'h2c000
`define ETG_ADDR_STATUS         18'h2c004

// mode field values
`define ETG_MODE_RISING         32'h00000001
`define ETG_MODE_FALLING        32'h00000002
`define ETG_MODE_LOW_LEVEL      32'h00000010
`define ETG_MODE_TWO_EDGE       32'h08000000
`define ETG_MODE_LONGER         32'h04000000

// source mask bit positions
`define ETG_MASK_MAIN_BIT       1
`define ETG_MASK_EXTRA_A_BIT    8
`define ETG_MASK_EXTRA_B_BIT    9

// reset values and the pulse width minimum
`define ETG_RST_SOURCE_MASK     32'h00000000
`define ETG_RST_GATE_MODE       32'h00000000
`define ETG_RST_PULSE_WIDTH     16'h0002
`define ETG_PW_MIN              16'h0002

`endif

// file: rtl/etg_pkg.sv
package etg_pkg;
    typedef enum logic [2:0] {
        ETG_SEL_NONE,
        ETG_SEL_LOW_LEVEL,
        ETG_SEL_FALL_TWO_EDGE,
        ETG_SEL_LONG_HIGH,
        ETG_SEL_LONG_LOW
    } etg_sel_t;

    typedef enum logic [1:0] {
        ETG_IDLE,
        ETG_ARMED,
        ETG_OPEN
    } etg_state_t;
endpackage

// file: rtl/etg_sync.sv
`timescale 1ns/1ps
module etg_sync
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // level in and out
    input  wire logic din,
    output logic      dout
);
    logic stage1;
    logic next_stage1;
    logic next_dout;

    always_comb
    begin
        next_stage1 = din;
        next_dout   = stage1;
    end

    // idle high: a line that powers up high is not seen as a rising edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1 <= 1'b1;
            dout   <= 1'b1;
        end
        else
        begin
            stage1 <= next_stage1;
            dout   <= next_dout;
        end
    end
endmodule // etg_sync

// file: test/etg_ttl_src.sv
`timescale 1ns/1ps
module etg_ttl_src
(
    // clock
    input  wire logic pclk,
    // ttl lines, idle high
    output logic      trig_main,
    output logic      trig_extra_a,
    output logic      trig_extra_b
);
    logic [2:0] line;

    initial line = 3'h7;

    assign trig_main    = line[0];
    assign trig_extra_a = line[1];
    assign trig_extra_b = line[2];

    // changes land just after an edge so the sampling never races
    task automatic drive(input int idx, input logic v);
        @(posedge pclk);
        line[idx] <= v;
    endtask

    // level v held for exactly n cycles, then back to the inverse
    task automatic pulse(input int idx, input logic v, input int n);
        drive(idx, v);
        repeat (n - 1) @(posedge pclk);
        drive(idx, ~v);
    endtask
endmodule // etg_ttl_src

// file: test/external_ttl_gate_trigger_tb_top.sv
`timescale 1ns/1ps
`include "etg_params.svh"
module external_ttl_gate_trigger_tb_top;
    localparam logic [31:0] A_MASK = {14'h0, `ETG_ADDR_SOURCE_MASK};
    localparam logic [31:0] A_MODE = {14'h0, `ETG_ADDR_GATE_MODE};
    localparam logic [31:0] A_PW   = {14'h0, `ETG_ADDR_PULSE_WIDTH};
    localparam logic [31:0] A_CTRL = {14'h0, `ETG_ADDR_CONTROL};
    localparam logic [31:0] A_STAT = {14'h0, `ETG_ADDR_STATUS};

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        t_main;
    logic        t_xa;
    logic        t_xb;
    logic        gate_open;
    logic [31:0] rd;
    logic        serr;
    int          errors;
    int          tests_run;

    etg_gate dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_trig_main(t_main),
        .ext_trig_extra_a(t_xa), .ext_trig_extra_b(t_xb), .gate_open(gate_open));

    etg_ttl_src src (.pclk(pclk), .trig_main(t_main), .trig_extra_a(t_xa),
        .trig_extra_b(t_xb));

    always #25 pclk = ~pclk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic fail(input string msg);
        errors++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd   = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fail("no pready");
            tally_and_finish();
        end
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic xerr);
        apb(1'b0, a, 32'h0);
        tests_run++;
        if (rd !== exp || serr !== xerr)
            fail("read data or error flag");
    endtask

    // stop, program, start: the board start is the 0 to 1 of run
    task automatic cfg(input logic [31:0] mask, input logic [31:0] mode);
        apb(1'b1, A_CTRL, 32'h0);
        apb(1'b1, A_MASK, mask);
        apb(1'b1, A_MODE, mode);
        apb(1'b1, A_CTRL, 32'h1);
    endtask

    task automatic gate_to(input logic v);
        int k;
        k = 0;
        while (gate_open !== v && k < 30)
        begin
            @(posedge pclk);
            k++;
        end
        tests_run++;
        if (gate_open !== v)
            fail("gate level not reached");
    endtask

    task automatic gate_holds(input logic v, input int n);
        int bad;
        bad = 0;
        repeat (n)
        begin
            @(posedge pclk);
            if (gate_open !== v)
                bad++;
        end
        tests_run++;
        if (bad != 0)
            fail("gate changed");
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        pclk      = 1'b0;
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 32'h0;
        pwdata    = 32'h0;
        errors    = 0;
        tests_run = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;

        rdchk(A_MASK, `ETG_RST_SOURCE_MASK, 1'b0);
        rdchk(A_MODE, `ETG_RST_GATE_MODE, 1'b0);
        rdchk(A_PW, {16'h0, `ETG_RST_PULSE_WIDTH}, 1'b0);
        apb(1'b1, A_PW, 32'h0000ffff);
        rdchk(A_PW, 32'h0000ffff, 1'b0);
        apb(1'b1, A_PW, 32'h00000001);
        rdchk(A_PW, {16'h0, `ETG_PW_MIN}, 1'b0);
        rdchk(32'h00000100, 32'h0, 1'b1);
        apb(1'b1, A_MASK, 32'h00000302);
        rdchk(A_MASK, 32'h00000302, 1'b0);
        $display("registers test done");

        src.drive(0, 1'b0);
        cfg(32'h00000002, `ETG_MODE_LOW_LEVEL);
        gate_to(1'b1);
        src.drive(0, 1'b1);
        gate_to(1'b0);
        src.drive(0, 1'b0);
        gate_to(1'b1);
        rdchk(A_STAT, 32'h00000005, 1'b0);
        src.drive(0, 1'b1);
        gate_to(1'b0);
        $display("low level test done");

        src.drive(0, 1'b0);
        src.drive(2, 1'b0);
        cfg(32'h00000100, `ETG_MODE_LOW_LEVEL);
        gate_holds(1'b0, 12);
        rdchk(A_STAT, 32'h00000003, 1'b0);
        src.drive(1, 1'b0);
        gate_to(1'b1);
        src.drive(1, 1'b1);
        gate_to(1'b0);
        cfg(32'h00000200, `ETG_MODE_LOW_LEVEL);
        gate_to(1'b1);
        src.drive(2, 1'b1);
        gate_to(1'b0);
        $display("source mask test done");

        cfg(32'h00000002, `ETG_MODE_TWO_EDGE | `ETG_MODE_FALLING);
        gate_holds(1'b0, 12);
        src.pulse(0, 1'b1, 4);
        gate_to(1'b1);
        src.drive(0, 1'b1);
        gate_holds(1'b1, 12);
        src.drive(0, 1'b0);
        gate_to(1'b0);
        $display("two edge test done");

        apb(1'b1, A_PW, 32'h00000008);
        cfg(32'h00000002, `ETG_MODE_LONGER | `ETG_MODE_RISING);
        // a pulse of exactly the limit must not qualify, one sample more must
        src.pulse(0, 1'b1, 8);
        gate_holds(1'b0, 20);
        src.drive(0, 1'b1);
        gate_holds(1'b0, 11);
        gate_holds(1'b1, 2);
        src.drive(0, 1'b0);
        gate_to(1'b0);
        $display("long high test done");

        src.drive(0, 1'b1);
        cfg(32'h00000002, `ETG_MODE_LONGER | `ETG_MODE_FALLING);
        src.pulse(0, 1'b0, 8);
        gate_holds(1'b0, 20);
        src.drive(0, 1'b0);
        gate_holds(1'b0, 11);
        gate_holds(1'b1, 2);
        src.drive(0, 1'b1);
        gate_to(1'b0);
        $display("long low test done");

        tally_and_finish();
    end
endmodule // external_ttl_gate_trigger_tb_top
